//--- design/cfg_router_pkg.sv
// constants for the configuration address router
`default_nettype none
package cfg_router_pkg;
  localparam logic [15:0] ADDR_PORT     = 16'h0cf8;
  localparam logic [15:0] DATA_PORT     = 16'h0cfc;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  localparam logic [31:0] ADDR_WMASK    = 32'h80ff_fffc;
  localparam logic [3:0]  BE_DWORD      = 4'hf;
  localparam int          EN_BIT        = 31;
  localparam int          BUS_HI        = 23;
  localparam int          BUS_LO        = 16;
  localparam int          DEV_HI        = 15;
  localparam int          DEV_LO        = 11;
  localparam int          FUNC_HI       = 10;
  localparam int          FUNC_LO       = 8;
  localparam int          REG_HI        = 7;
  localparam int          REG_LO        = 2;
  localparam logic [7:0]  BUS_ZERO      = 8'h00;
  localparam logic [4:0]  DEV_HOST_HUB  = 5'h00;
  localparam logic [4:0]  DEV_SEC_BRG   = 5'h01;
  localparam logic [4:0]  DEV_GRAPHICS  = 5'h02;
  localparam logic [2:0]  FUNC_ZERO     = 3'h0;
  localparam logic [15:0] IDSEL_ONE     = 16'h0001;
  localparam logic [1:0]  TYPE0         = 2'h0;
  localparam logic [1:0]  TYPE1         = 2'h1;
  localparam int          IDSEL_HI      = 31;
  localparam int          IDSEL_LO      = 16;
  localparam int          CTYPE_HI      = 1;
  localparam int          CTYPE_LO      = 0;
  localparam int          DEV_HIGH_BIT  = 4;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_INTERNAL, TGT_HUB, TGT_SEC, TGT_IO_PASS
  } target_t;
endpackage
`default_nettype wire

//--- design/config_address_router.sv
// configuration address register and configuration cycle router
`default_nettype none
module config_address_router (
  // clock, reset, enable
  input  wire  logic        sys_clk_i,
  input  wire  logic        srst_i,
  input  wire  logic        clk_en_i,
  // processor io cycle
  input  wire  logic        io_req_i,
  input  wire  logic        io_write_i,
  input  wire  logic [15:0] io_addr_i,
  input  wire  logic [3:0]  io_be_i,
  input  wire  logic [31:0] io_wdata_i,
  output var   logic        io_ack_o,
  output var   logic [31:0] io_rdata_o,
  // secondary bridge bus numbers
  input  wire  logic [7:0]  sec_bus_num_i,
  input  wire  logic [7:0]  sub_bus_num_i,
  // routed cycle
  output var   logic        cfg_valid_o,
  output var   logic        cfg_write_o,
  output var   logic [3:0]  cfg_be_o,
  output var   logic [31:0] cfg_wdata_o,
  output var   logic        internal_sel_o,
  output var   logic [4:0]  internal_dev_o,
  output var   logic        hub_link_o,
  output var   logic        io_pass_o,
  output var   logic [15:0] io_pass_addr_o,
  output var   logic        sec_bus_o,
  output var   logic [1:0]  cfg_type_o,
  output var   logic [31:0] graphics_addr_data_lines_o,
  output var   logic        sec_master_abort_o,
  output var   logic        cfg_access_enable_o
);
  typedef struct packed {
    logic [31:0] cfg_target_select;
    logic        ack;
    logic [31:0] rdata;
    logic        valid;
    logic        write;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic        int_sel;
    logic [4:0]  int_dev;
    logic        hub;
    logic        pass;
    logic [15:0] pass_addr;
    logic        sec;
    logic [1:0]  ctype;
    logic [31:0] lines;
    logic        abort;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [7:0]  bus;
  logic [4:0]  dev;
  logic [2:0]  func;
  logic [5:0]  regn;
  logic        enable;
  logic        dword;
  logic        hit_addr;
  logic        hit_data;
  cfg_router_pkg::target_t tgt;
  logic        is_type0;

  assign bus    = st.cfg_target_select[cfg_router_pkg::BUS_HI:cfg_router_pkg::BUS_LO];
  assign dev    = st.cfg_target_select[cfg_router_pkg::DEV_HI:cfg_router_pkg::DEV_LO];
  assign func   = st.cfg_target_select[cfg_router_pkg::FUNC_HI:cfg_router_pkg::FUNC_LO];
  assign regn   = st.cfg_target_select[cfg_router_pkg::REG_HI:cfg_router_pkg::REG_LO];
  assign enable = st.cfg_target_select[cfg_router_pkg::EN_BIT];
  assign dword  = (io_be_i == cfg_router_pkg::BE_DWORD);
  assign hit_addr = io_req_i && (io_addr_i == cfg_router_pkg::ADDR_PORT);
  assign hit_data = io_req_i && (io_addr_i == cfg_router_pkg::DATA_PORT);

  always_comb begin
    tgt      = cfg_router_pkg::TGT_NONE;
    is_type0 = 1'b0;
    if (hit_addr && !dword) begin
      tgt = cfg_router_pkg::TGT_IO_PASS;
    end else if (hit_data && enable) begin
      if (bus == cfg_router_pkg::BUS_ZERO) begin
        if (dev == cfg_router_pkg::DEV_HOST_HUB || dev == cfg_router_pkg::DEV_SEC_BRG ||
            dev == cfg_router_pkg::DEV_GRAPHICS) begin
          // internal cycle stays inside; nonzero function dropped
          if (func == cfg_router_pkg::FUNC_ZERO) begin
            tgt = cfg_router_pkg::TGT_INTERNAL;
          end else begin
            tgt = cfg_router_pkg::TGT_NONE;
          end
        end else begin
          tgt = cfg_router_pkg::TGT_HUB;
        end
      end else if (bus == sec_bus_num_i) begin
        tgt      = cfg_router_pkg::TGT_SEC;
        is_type0 = 1'b1;
      end else if (bus > sec_bus_num_i && bus <= sub_bus_num_i) begin
        tgt = cfg_router_pkg::TGT_SEC;
      end else begin
        tgt = cfg_router_pkg::TGT_HUB;
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.valid = 1'b0;
    next_st.pass  = 1'b0;
    next_st.abort = 1'b0;
    if (hit_addr && dword) begin
      if (io_write_i) begin
        // reserved bits masked so they never store
        next_st.cfg_target_select = io_wdata_i & cfg_router_pkg::ADDR_WMASK;
      end
      next_st.rdata = st.cfg_target_select;
      next_st.ack   = 1'b1;
    end
    if (tgt == cfg_router_pkg::TGT_IO_PASS) begin
      next_st.pass      = 1'b1;
      next_st.pass_addr = io_addr_i;
      next_st.write     = io_write_i;
      next_st.be        = io_be_i;
      next_st.wdata     = io_wdata_i;
    end
    if (tgt != cfg_router_pkg::TGT_NONE && tgt != cfg_router_pkg::TGT_IO_PASS) begin
      next_st.valid   = 1'b1;
      next_st.write   = io_write_i;
      next_st.be      = io_be_i;
      next_st.wdata   = io_wdata_i;
      next_st.int_sel = (tgt == cfg_router_pkg::TGT_INTERNAL);
      next_st.int_dev = dev;
      next_st.hub     = (tgt == cfg_router_pkg::TGT_HUB);
      next_st.sec     = (tgt == cfg_router_pkg::TGT_SEC);
      next_st.ctype   = is_type0 ? cfg_router_pkg::TYPE0 : cfg_router_pkg::TYPE1;
      next_st.lines   = '0;
      next_st.lines[cfg_router_pkg::FUNC_HI:cfg_router_pkg::FUNC_LO] = func;
      next_st.lines[cfg_router_pkg::REG_HI:cfg_router_pkg::REG_LO]   = regn;
      if (is_type0) begin
        // device above 15 shifts out, leaving no idsel
        next_st.lines[cfg_router_pkg::IDSEL_HI:cfg_router_pkg::IDSEL_LO] =
          cfg_router_pkg::IDSEL_ONE << dev;
        next_st.abort = dev[cfg_router_pkg::DEV_HIGH_BIT];
      end else begin
        next_st.lines[cfg_router_pkg::BUS_HI:cfg_router_pkg::BUS_LO] = bus;
        next_st.lines[cfg_router_pkg::DEV_HI:cfg_router_pkg::DEV_LO] = dev;
        next_st.lines[cfg_router_pkg::CTYPE_HI:cfg_router_pkg::CTYPE_LO] = cfg_router_pkg::TYPE1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st                   <= '0;
      st.cfg_target_select <= cfg_router_pkg::ADDR_RESET;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign io_ack_o                   = st.ack;
  assign io_rdata_o                 = st.rdata;
  assign cfg_valid_o                = st.valid;
  assign cfg_write_o                = st.write;
  assign cfg_be_o                   = st.be;
  assign cfg_wdata_o                = st.wdata;
  assign internal_sel_o             = st.int_sel;
  assign internal_dev_o             = st.int_dev;
  assign hub_link_o                 = st.hub;
  assign io_pass_o                  = st.pass;
  assign io_pass_addr_o             = st.pass_addr;
  assign sec_bus_o                  = st.sec;
  assign cfg_type_o                 = st.ctype;
  assign graphics_addr_data_lines_o = st.lines;
  assign sec_master_abort_o         = st.abort;
  assign cfg_access_enable_o        = enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  chk_reserved_zero: assert property (
    (st.cfg_target_select & ~cfg_router_pkg::ADDR_WMASK) == 32'h0000_0000)
    else $error("reserved address bits set");
  chk_dword_write: assert property (clk_en_i && hit_addr && dword && io_write_i |=>
    st.cfg_target_select == ($past(io_wdata_i) & cfg_router_pkg::ADDR_WMASK))
    else $error("address register not loaded");
  chk_narrow_pass: assert property (clk_en_i && hit_addr && !dword |=> io_pass_o &&
    $stable(st.cfg_target_select)) else $error("narrow access not passed");
  chk_disabled_none: assert property (clk_en_i && hit_data && !enable |=> !cfg_valid_o)
    else $error("cycle while disabled");
  chk_internal_nohub: assert property (internal_sel_o |-> !hub_link_o)
    else $error("internal cycle on hub");
  chk_idsel_onehot: assert property (cfg_valid_o && sec_bus_o &&
    cfg_type_o == cfg_router_pkg::TYPE0 && !sec_master_abort_o |->
    $onehot(graphics_addr_data_lines_o[cfg_router_pkg::IDSEL_HI:cfg_router_pkg::IDSEL_LO]))
    else $error("idsel not one-hot");
  chk_abort_noidsel: assert property (sec_master_abort_o |->
    graphics_addr_data_lines_o[cfg_router_pkg::IDSEL_HI:cfg_router_pkg::IDSEL_LO] == '0)
    else $error("idsel with high device");
  chk_func_internal: assert property (clk_en_i && hit_data && enable &&
    bus == cfg_router_pkg::BUS_ZERO && dev <= cfg_router_pkg::DEV_GRAPHICS &&
    func != cfg_router_pkg::FUNC_ZERO |=> !cfg_valid_o)
    else $error("nonzero function served");
  chk_type1_range: assert property (clk_en_i && hit_data && enable &&
    bus != cfg_router_pkg::BUS_ZERO &&
    (bus < sec_bus_num_i || bus > sub_bus_num_i) |=> hub_link_o && cfg_valid_o)
    else $error("out of range not to hub");

  cov_type0: cover property (cfg_valid_o && sec_bus_o &&
    cfg_type_o == cfg_router_pkg::TYPE0);
  cov_type1_sec: cover property (cfg_valid_o && sec_bus_o &&
    cfg_type_o == cfg_router_pkg::TYPE1);
  cov_abort: cover property (sec_master_abort_o);
  cov_internal: cover property (cfg_valid_o && internal_sel_o);
  cov_pass: cover property (io_pass_o);
endmodule
`default_nettype wire

//--- test/host_io_model.sv
// host processor model issuing single io cycles
`default_nettype none
module host_io_model (
  // clock
  input  wire logic        sys_clk_i,
  // io cycle
  output var  logic        io_req_o,
  output var  logic        io_write_o,
  output var  logic [15:0] io_addr_o,
  output var  logic [3:0]  io_be_o,
  output var  logic [31:0] io_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_req_o = 1'b0;
    {io_write_o, io_addr_o, io_be_o, io_wdata_o} = '0;
  end
  // one request per call; idle lines scrambled since nothing pulls them
  task automatic issue(input logic w, input logic [15:0] a, input logic [3:0] be,
                       input logic [31:0] d);
    @(negedge sys_clk_i);
    io_req_o = 1'b1;
    {io_write_o, io_addr_o, io_be_o, io_wdata_o} = {w, a, be, d};
    @(negedge sys_clk_i);
    io_req_o = 1'b0;
    {io_write_o, io_addr_o, io_be_o, io_wdata_o} = ~{w, a, be, d};
  endtask
endmodule
`default_nettype wire

//--- test/config_address_router_tb.sv
// self-checking bench for the configuration address router
`default_nettype none
module config_address_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        req, wr, ack, vld, cwr, isel, hub, pass, sec, abort, en;
  logic [15:0] addr, paddr;
  logic [3:0]  be, cbe;
  logic [31:0] wdata, rdata, lines, cwdata, shadow, v;
  logic [4:0]  idev;
  logic [1:0]  ctype;
  logic [7:0]  sec_num   = 8'h03;
  logic [7:0]  sub_num   = 8'h06;
  logic [31:0] lfsr      = 32'h96ec_fdfb;
  logic        clk_en    = 1'b1;
  logic [31:0] corners [12] = '{32'hffff_ffff, 32'h8000_0004, 32'h8000_1104, 32'h8000_1800,
    32'h8003_0000, 32'h8003_78fc, 32'h8003_8000, 32'h8004_0000, 32'h8006_f800, 32'h8007_0000,
    32'h8002_0000, 32'h7fff_ffff};
  int          error_cnt, checks_done, cycles;
  always #50 sys_clk_i = ~sys_clk_i;
  host_io_model host_io_model_inst (.sys_clk_i(sys_clk_i), .io_req_o(req), .io_write_o(wr),
    .io_addr_o(addr), .io_be_o(be), .io_wdata_o(wdata));
  config_address_router config_address_router_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .clk_en_i(clk_en), .io_req_i(req), .io_write_i(wr), .io_addr_i(addr), .io_be_i(be),
    .io_wdata_i(wdata), .io_ack_o(ack), .io_rdata_o(rdata), .sec_bus_num_i(sec_num),
    .sub_bus_num_i(sub_num), .cfg_valid_o(vld), .cfg_write_o(cwr), .cfg_be_o(cbe),
    .cfg_wdata_o(cwdata), .internal_sel_o(isel), .internal_dev_o(idev), .hub_link_o(hub),
    .io_pass_o(pass), .io_pass_addr_o(paddr), .sec_bus_o(sec), .cfg_type_o(ctype),
    .graphics_addr_data_lines_o(lines), .sec_master_abort_o(abort),
    .cfg_access_enable_o(en));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one io cycle, then outputs checked against the shadow register; valid and abort on every data port cycle, the other routing outputs only on ones that hit
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    logic       dw, inter, hit, s0, s1;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [15:0] idsel;
    host_io_model_inst.issue(w, a, b, d);
    dw = (a == 16'h0cf8);
    check(ack, dw && b == 4'hf);
    check(pass, dw && b != 4'hf);
    if (pass === 1'b1) check(paddr, a);
    if (pass === 1'b1) check(cbe, b);
    if (pass === 1'b1) check(cwdata, d);
    if (dw && b == 4'hf) begin
      check(rdata, shadow);
      if (w) shadow = d & 32'h80ff_fffc;
    end
    check(en, shadow[31]);
    if (a != 16'h0cfc) return;
    bus = shadow[23:16];
    dev = shadow[15:11];
    inter = bus == 8'h00 && dev <= 5'h02;
    hit = shadow[31] && !(inter && shadow[10:8] != 3'h0);
    s0 = bus != 8'h00 && bus == sec_num;
    s1 = bus != 8'h00 && bus > sec_num && bus <= sub_num;
    idsel = dev[4] ? 16'h0000 : 16'h0001 << dev;
    check(vld, hit);
    check(abort, hit && s0 && dev[4]);
    if (!hit) return;
    check(isel, inter);
    check(hub, !inter && !s0 && !s1);
    check(sec, s0 || s1);
    check(cwr, w);
    check(cwdata, d);
    check(cbe, b);
    if (inter) check(idev, dev);
    else check(lines[10:2], shadow[10:2]);
    if (s0) check(ctype, 2'h0);
    if (s0) check(lines, {idsel, 5'h0, shadow[10:2], 2'h0});
    if (!inter && !s0) check(lines, {8'h0, shadow[23:2], 2'h1});
    if (bus != 8'h00 && !s0) check(ctype, 2'h1);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    shadow = 32'h0000_0000;
    repeat (8) @(negedge sys_clk_i);
    srst_i = 1'b0;
    acc(1'b0, 16'h0cf8, 4'hf, 32'h0);
    acc(1'b0, 16'h0cfc, 4'hf, 32'h0);
    // corners: bus 0 devices, idsel ends, range edges, reserved bits, disable
    foreach (corners[i]) begin
      acc(1'b1, 16'h0cf8, 4'hf, corners[i]);
      acc(i[0], 16'h0cfc, 4'hf, rnd());
    end
    // frozen clock enable: a dword write must not land
    @(negedge sys_clk_i);
    clk_en = 1'b0;
    host_io_model_inst.issue(1'b1, 16'h0cf8, 4'hf, 32'h8000_0000);
    check(ack, 1'b0);
    check(en, shadow[31]);
    clk_en = 1'b1;
    acc(1'b0, 16'h0cf8, 4'hf, 32'h0);
    acc(1'b1, 16'h0cf8, 4'h1, 32'h0);
    acc(1'b1, 16'h0cf8, 4'h3, 32'h0);
    acc(1'b1, 16'h0080, 4'hf, 32'h0);
    // reset in mid-run clears the register
    acc(1'b1, 16'h0cf8, 4'hf, 32'h8000_0000);
    @(negedge sys_clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    shadow = 32'h0000_0000;
    check(en, 1'b0);
    check(vld, 1'b0);
    acc(1'b0, 16'h0cf8, 4'hf, 32'h0);
    for (int k = 0; k < 200; k++) begin
      // second half moves the bridge window
      if (k == 100) begin
        sec_num = 8'h10;
        sub_num = 8'h80;
      end
      v = rnd();
      v[31] = |v[4:3];
      case (v[2:0])
        3'h0: v[23:16] = 8'h00;
        3'h1: v[23:16] = sec_num;
        3'h2: v[23:16] = sub_num;
        default: ;
      endcase
      acc(1'b1, 16'h0cf8, v[5] ? 4'hf : v[7:4], v);
      acc(v[6], 16'h0cfc, 4'hf, rnd());
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
